// ===== hw/pmcs_ctrl.sv
`timescale 1ns/1ns
module pmcs_ctrl (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Control bits
    input wire logic [1:0] clock_select_field_in,
    input wire logic idle_enable_bit_in,
    input wire logic timer_osc_enable_bit_in,
    input wire logic sleep_instr_in,
    input wire logic two_speed_en_in,
    input wire logic fail_safe_en_in,
    input wire logic watchdog_en_in,
    // Wake sources
    input wire logic interrupt_in,
    input wire logic watchdog_timeout_in,
    // Oscillator status and sampled clocks
    input wire logic primary_ready_in,
    input wire logic timer_osc_running_in,
    input wire logic primary_clk_in,
    input wire logic timer_osc_clk_in,
    input wire logic rc_clk_in,
    // Oscillator enables
    output logic primary_osc_en_out,
    output logic timer_osc_en_out,
    output logic rc_osc_en_out,
    // Clock gates and source
    output logic [2:0] clock_source_out,
    output logic cpu_clk_en_out,
    output logic periph_clk_en_out,
    output logic cpu_exec_out,
    // Status
    output logic primary_status_flag_out,
    output logic timer_osc_running_flag_out,
    output logic watchdog_reset_out
);

    pmcs_pkg::pmcs_mode_t mode_r;
    logic [2:0] src_r;
    logic [2:0] target_r;
    logic [2:0] old_cnt_r;
    logic [2:0] new_cnt_r;
    logic [7:0] delay_r;
    logic [1:0] sel_seen_r;
    logic primary_flag_r;
    logic timer_flag_r;
    logic cpu_en_r;
    logic periph_en_r;
    logic exec_r;
    logic wdt_rst_r;
    logic pri_en_r;
    logic sec_en_r;
    logic rc_en_r;
    logic [2:0] want_src;
    logic want_ok;
    logic sel_change;
    logic wake;
    logic [2:0] src_edge;

    pmcs_edge_if edges ();

    assign edges.src_clk = {rc_clk_in, timer_osc_clk_in, primary_clk_in};
    assign src_edge = edges.src_edge;

    pmcs_edge_det u_edge (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .edges(edges)
    );

    // ****************************************
    // Requested source and readiness
    // ****************************************
    always_comb begin
        want_src = pmcs_pkg::sel_to_src(clock_select_field_in);
        want_ok = 1'b1;
        if (want_src[pmcs_pkg::SRC_SEC] && !timer_osc_enable_bit_in) begin
            want_ok = 1'b0;
        end
        if (want_src[pmcs_pkg::SRC_PRI] && !primary_ready_in) begin
            want_ok = 1'b0;
        end
    end

    assign sel_change = clock_select_field_in != sel_seen_r;
    assign wake = interrupt_in | watchdog_timeout_in;

    // ****************************************
    // Mode sequencing
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_r <= pmcs_pkg::MODE_RUN;
        end else begin
            unique case (mode_r)
                pmcs_pkg::MODE_RUN: begin
                    if (sleep_instr_in && !watchdog_timeout_in) begin
                        if (idle_enable_bit_in) begin
                            mode_r <= pmcs_pkg::MODE_IDLE;
                        end else begin
                            mode_r <= pmcs_pkg::MODE_SLEEP;
                        end
                    end else if (want_src != src_r && want_ok) begin
                        mode_r <= pmcs_pkg::MODE_SWITCH;
                    end
                end
                pmcs_pkg::MODE_SWITCH: begin
                    if (new_cnt_r == pmcs_pkg::NEW_SRC_CYCLES) begin
                        mode_r <= pmcs_pkg::MODE_RUN;
                    end
                end
                pmcs_pkg::MODE_IDLE: begin
                    if (wake) begin
                        mode_r <= pmcs_pkg::MODE_READY_DELAY;
                    end
                end
                pmcs_pkg::MODE_SLEEP: begin
                    if (wake) begin
                        mode_r <= pmcs_pkg::MODE_WAKE_WAIT;
                    end
                end
                pmcs_pkg::MODE_WAKE_WAIT: begin
                    if (want_ok) begin
                        mode_r <= pmcs_pkg::MODE_READY_DELAY;
                    end
                end
                pmcs_pkg::MODE_READY_DELAY: begin
                    if (delay_r == 8'h01) begin
                        mode_r <= pmcs_pkg::MODE_RUN;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Clock switch counting
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            target_r <= 3'h1;
            old_cnt_r <= 3'h0;
            new_cnt_r <= 3'h0;
        end else if (mode_r == pmcs_pkg::MODE_RUN) begin
            target_r <= want_src;
            old_cnt_r <= 3'h0;
            new_cnt_r <= 3'h0;
        end else if (mode_r == pmcs_pkg::MODE_SWITCH) begin
            if (old_cnt_r != pmcs_pkg::OLD_SRC_CYCLES) begin
                if (|(src_edge & src_r)) begin
                    old_cnt_r <= old_cnt_r + 3'h1;
                end
            end else if (|(src_edge & target_r)) begin
                new_cnt_r <= new_cnt_r + 3'h1;
            end
        end
    end

    // ****************************************
    // Active source and status flags
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            src_r <= 3'h1;
            primary_flag_r <= 1'b1;
            timer_flag_r <= 1'b0;
            sel_seen_r <= pmcs_pkg::SEL_RESET;
        end else begin
            sel_seen_r <= clock_select_field_in;
            if (mode_r == pmcs_pkg::MODE_SWITCH &&
                new_cnt_r == pmcs_pkg::NEW_SRC_CYCLES) begin
                src_r <= target_r;
                primary_flag_r <= target_r[pmcs_pkg::SRC_PRI];
                timer_flag_r <= target_r[pmcs_pkg::SRC_SEC];
            end else if (mode_r == pmcs_pkg::MODE_RUN && sleep_instr_in &&
                         !idle_enable_bit_in && !watchdog_timeout_in) begin
                primary_flag_r <= 1'b0;
                timer_flag_r <= 1'b0;
            end else if (mode_r == pmcs_pkg::MODE_WAKE_WAIT && want_ok) begin
                src_r <= want_src;
                primary_flag_r <= want_src[pmcs_pkg::SRC_PRI];
                timer_flag_r <= want_src[pmcs_pkg::SRC_SEC];
            end
        end
    end

    // ****************************************
    // Clock gates and execution
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cpu_en_r <= 1'b1;
            periph_en_r <= 1'b1;
            exec_r <= 1'b1;
            delay_r <= 8'h00;
        end else begin
            unique case (mode_r)
                pmcs_pkg::MODE_RUN, pmcs_pkg::MODE_SWITCH: begin
                    periph_en_r <= !(src_r[pmcs_pkg::SRC_SEC] &&
                                     !timer_osc_running_in);
                    cpu_en_r <= !(src_r[pmcs_pkg::SRC_SEC] &&
                                  !timer_osc_running_in);
                    exec_r <= 1'b1;
                    delay_r <= pmcs_pkg::CPU_READY_CNT;
                    if (sleep_instr_in && mode_r == pmcs_pkg::MODE_RUN &&
                        !watchdog_timeout_in) begin
                        cpu_en_r <= 1'b0;
                        exec_r <= 1'b0;
                        periph_en_r <= idle_enable_bit_in;
                    end
                end
                pmcs_pkg::MODE_IDLE: begin
                    cpu_en_r <= 1'b0;
                    periph_en_r <= 1'b1;
                    exec_r <= 1'b0;
                end
                pmcs_pkg::MODE_SLEEP, pmcs_pkg::MODE_WAKE_WAIT: begin
                    cpu_en_r <= 1'b0;
                    exec_r <= 1'b0;
                    periph_en_r <= mode_r == pmcs_pkg::MODE_WAKE_WAIT &&
                                   (two_speed_en_in || fail_safe_en_in);
                end
                pmcs_pkg::MODE_READY_DELAY: begin
                    delay_r <= delay_r - 8'h01;
                    periph_en_r <= 1'b1;
                    cpu_en_r <= delay_r == 8'h01;
                    exec_r <= delay_r == 8'h01;
                end
            endcase
        end
    end

    // ****************************************
    // Oscillator enables
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pri_en_r <= 1'b1;
            sec_en_r <= 1'b0;
            rc_en_r <= 1'b1;
        end else begin
            pri_en_r <= (mode_r == pmcs_pkg::MODE_RUN ||
                         mode_r == pmcs_pkg::MODE_IDLE ||
                         mode_r == pmcs_pkg::MODE_READY_DELAY) ?
                        (src_r[pmcs_pkg::SRC_PRI] ||
                         want_src[pmcs_pkg::SRC_PRI]) :
                        (mode_r == pmcs_pkg::MODE_SWITCH) ?
                        (target_r[pmcs_pkg::SRC_PRI] ||
                         src_r[pmcs_pkg::SRC_PRI]) :
                        (mode_r == pmcs_pkg::MODE_WAKE_WAIT) &&
                        want_src[pmcs_pkg::SRC_PRI];
            sec_en_r <= timer_osc_enable_bit_in;
            // RC kept for watchdog or monitor
            rc_en_r <= watchdog_en_in || fail_safe_en_in ||
                       src_r[pmcs_pkg::SRC_RC] ||
                       (mode_r == pmcs_pkg::MODE_SWITCH &&
                        target_r[pmcs_pkg::SRC_RC]) ||
                       (mode_r == pmcs_pkg::MODE_WAKE_WAIT &&
                        (two_speed_en_in || want_src[pmcs_pkg::SRC_RC]));
        end
    end

    // ****************************************
    // Watchdog while running
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wdt_rst_r <= 1'b0;
        end else begin
            wdt_rst_r <= watchdog_timeout_in &&
                         (mode_r == pmcs_pkg::MODE_RUN ||
                          mode_r == pmcs_pkg::MODE_SWITCH);
        end
    end

    // Select bits are inputs, never written
    // Internal select turns primary off via pri_en_r
    assign primary_osc_en_out = pri_en_r;
    assign timer_osc_en_out = sec_en_r;
    assign rc_osc_en_out = rc_en_r;
    assign clock_source_out = src_r;
    assign cpu_clk_en_out = cpu_en_r;
    assign periph_clk_en_out = periph_en_r;
    assign cpu_exec_out = exec_r;
    assign primary_status_flag_out = primary_flag_r;
    assign timer_osc_running_flag_out = timer_flag_r;
    assign watchdog_reset_out = wdt_rst_r;

    logic unused_sel_change;
    assign unused_sel_change = sel_change;

endmodule

// ===== hw/pmcs_pkg.sv
package pmcs_pkg;

    // ****************************************
    // Clock select encodings
    // ****************************************
    localparam logic [1:0] SEL_INTERNAL_ALT = 2'h0;
    localparam logic [1:0] SEL_SECONDARY = 2'h1;
    localparam logic [1:0] SEL_PRIMARY = 2'h2;
    localparam logic [1:0] SEL_INTERNAL = 2'h3;

    // ****************************************
    // Source one-hot positions
    // ****************************************
    localparam int SRC_PRI = 0;
    localparam int SRC_SEC = 1;
    localparam int SRC_RC = 2;
    localparam int NUM_SRC = 3;

    // ****************************************
    // Switch timing, in source cycles
    // ****************************************
    localparam logic [2:0] OLD_SRC_CYCLES = 3'h2;
    localparam logic [2:0] NEW_SRC_CYCLES = 3'h4;

    // ****************************************
    // CPU ready delay
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int CPU_READY_DELAY_NS = 200;
    localparam int CPU_READY_CYCLES =
        (CPU_READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] CPU_READY_CNT = 8'(CPU_READY_CYCLES);

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [1:0] SEL_RESET = SEL_PRIMARY;
    localparam logic IDLE_EN_RESET = 1'b0;

    // ****************************************
    // Modes
    // ****************************************
    typedef enum logic [2:0] {
        MODE_RUN,
        MODE_SWITCH,
        MODE_IDLE,
        MODE_SLEEP,
        MODE_WAKE_WAIT,
        MODE_READY_DELAY
    } pmcs_mode_t;

    // Map a clock select value to a one-hot source
    function automatic logic [2:0] sel_to_src(input logic [1:0] sel);
        logic [2:0] src;
        src = 3'h0;
        unique case (sel)
            SEL_PRIMARY: src[SRC_PRI] = 1'b1;
            SEL_SECONDARY: src[SRC_SEC] = 1'b1;
            default: src[SRC_RC] = 1'b1;
        endcase
        return src;
    endfunction

endpackage

// ===== hw/pmcs_edge_if.sv
`timescale 1ns/1ns
interface pmcs_edge_if;
    logic [2:0] src_clk;
    logic [2:0] src_edge;

    modport det (
        input src_clk,
        output src_edge
    );
    modport use_edge (
        input src_edge
    );
endinterface

// ===== hw/pmcs_edge_det.sv
`timescale 1ns/1ns
module pmcs_edge_det (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Oscillator levels and edges
    pmcs_edge_if.det edges
);

    logic [2:0] last_r;

    // ****************************************
    // Rising edge of each sampled source
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            last_r <= 3'h0;
        end else begin
            last_r <= edges.src_clk;
        end
    end

    genvar g;
    generate
        for (g = 0; g < pmcs_pkg::NUM_SRC; g++) begin : g_edge
            assign edges.src_edge[g] = edges.src_clk[g] & ~last_r[g];
        end
    endgenerate

endmodule

// ===== sim/pmcs_ctrl_monitor.sv
`timescale 1ns/1ns
module pmcs_ctrl_monitor (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Watched inputs
    input wire logic idle_enable_bit_in,
    input wire logic timer_osc_enable_bit_in,
    input wire logic sleep_instr_in,
    input wire logic watchdog_timeout_in,
    input wire logic primary_ready_in,
    // Watched outputs
    input wire logic [2:0] clock_source_out,
    input wire logic cpu_clk_en_out,
    input wire logic periph_clk_en_out,
    input wire logic cpu_exec_out,
    input wire logic primary_status_flag_out,
    input wire logic timer_osc_running_flag_out,
    input wire logic watchdog_reset_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // ****************************************
    // Cycles with the CPU halted
    // ****************************************
    logic [7:0] low_cnt_r;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            low_cnt_r <= 8'h00;
        end else if (cpu_exec_out) begin
            low_cnt_r <= 8'h00;
        end else if (low_cnt_r != 8'hFF) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    a_primary_flag_src: assert property (
        primary_status_flag_out |-> clock_source_out == 3'h1)
        else $error("primary flag without primary source");
    a_timer_flag_src: assert property (
        timer_osc_running_flag_out |-> clock_source_out == 3'h2)
        else $error("timer flag without timer source");
    a_timer_needs_en: assert property (
        $rose(clock_source_out[1]) |-> timer_osc_enable_bit_in)
        else $error("timer source taken while disabled");
    a_primary_needs_ready: assert property (
        $rose(clock_source_out[0]) |-> primary_ready_in)
        else $error("primary source taken before ready");
    a_cpu_gate_cause: assert property (
        $fell(cpu_clk_en_out) && !clock_source_out[1]
        |-> $past(sleep_instr_in))
        else $error("cpu gate dropped without sleep");
    a_idle_keeps_periph: assert property (
        $fell(cpu_clk_en_out) && $past(idle_enable_bit_in)
        |-> periph_clk_en_out && $stable(primary_status_flag_out)
        && $stable(timer_osc_running_flag_out))
        else $error("idle entry disturbed periph or flags");
    a_sleep_stops_all: assert property (
        $fell(cpu_clk_en_out) && !$past(idle_enable_bit_in)
        && !clock_source_out[1] |-> ##[0:1] (!periph_clk_en_out
        && !primary_status_flag_out && !timer_osc_running_flag_out))
        else $error("sleep entry left clocks or flags");
    a_wdt_reset_cause: assert property (
        watchdog_reset_out
        |-> $past(watchdog_timeout_in) && $past(cpu_exec_out))
        else $error("watchdog reset without running timeout");
    a_ready_delay_len: assert property (
        $rose(cpu_exec_out)
        |-> low_cnt_r >= 8'(pmcs_pkg::CPU_READY_CYCLES - 1))
        else $error("execution resumed before ready delay");
endmodule

bind pmcs_ctrl pmcs_ctrl_monitor pmcs_ctrl_monitor_i (.clk_in, .nrst_in,
    .idle_enable_bit_in, .timer_osc_enable_bit_in, .sleep_instr_in,
    .watchdog_timeout_in, .primary_ready_in, .clock_source_out,
    .cpu_clk_en_out, .periph_clk_en_out, .cpu_exec_out,
    .primary_status_flag_out, .timer_osc_running_flag_out,
    .watchdog_reset_out);

// ===== sim/pmcs_osc_model.sv
`timescale 1ns/1ns
module pmcs_osc_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Enables and start-up speed
    input wire logic pri_en_in,
    input wire logic tmr_en_in,
    input wire logic rc_en_in,
    input wire logic slow_in,
    // Oscillator outputs
    output logic pri_ready_out,
    output logic tmr_run_out,
    output logic pri_clk_out,
    output logic tmr_clk_out,
    output logic rc_clk_out
);
    logic [7:0] div_r, pcnt_r, tcnt_r, lim;
    assign lim = slow_in ? 8'hC8 : 8'h28;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end
    // Primary counts its start-up while enabled
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pcnt_r <= 8'hFF;
        end else if (!pri_en_in) begin
            pcnt_r <= 8'h00;
        end else if (pcnt_r != 8'hFF) begin
            pcnt_r <= pcnt_r + 8'h01;
        end
    end
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tcnt_r <= 8'h00;
        end else if (!tmr_en_in) begin
            tcnt_r <= 8'h00;
        end else if (tcnt_r != 8'hFF) begin
            tcnt_r <= tcnt_r + 8'h01;
        end
    end
    // Stopped oscillators stand at low
    assign pri_ready_out = pri_en_in && pcnt_r >= lim;
    assign tmr_run_out = tmr_en_in && tcnt_r >= 8'h1E;
    assign pri_clk_out = pri_ready_out & div_r[1];
    assign tmr_clk_out = tmr_run_out & div_r[3];
    assign rc_clk_out = rc_en_in & div_r[2];
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk_in = 1'b0, nrst_in = 1'b0;
    logic [1:0] sel = 2'h2;
    logic idle = 1'b0, ten = 1'b0, slp = 1'b0, irq = 1'b0, wdt = 1'b0;
    logic slow = 1'b0, tsp = 1'b0;
    logic p_rdy, t_run, p_clk, t_clk, r_clk, p_en, t_en, r_en;
    logic cpu_en, per_en, exec, f_pri, f_tmr, wd_rst;
    logic [2:0] src;
    int num_errors = 0, num_checks = 0;

    always #5 clk_in = ~clk_in;

    pmcs_ctrl pmcs_ctrl_i (.clk_in(clk_in), .nrst_in(nrst_in),
        .clock_select_field_in(sel), .idle_enable_bit_in(idle),
        .timer_osc_enable_bit_in(ten), .sleep_instr_in(slp),
        .two_speed_en_in(tsp), .fail_safe_en_in(1'b0),
        .watchdog_en_in(1'b1), .interrupt_in(irq),
        .watchdog_timeout_in(wdt), .primary_ready_in(p_rdy),
        .timer_osc_running_in(t_run), .primary_clk_in(p_clk),
        .timer_osc_clk_in(t_clk), .rc_clk_in(r_clk),
        .primary_osc_en_out(p_en), .timer_osc_en_out(t_en),
        .rc_osc_en_out(r_en), .clock_source_out(src),
        .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
        .cpu_exec_out(exec), .primary_status_flag_out(f_pri),
        .timer_osc_running_flag_out(f_tmr), .watchdog_reset_out(wd_rst));

    pmcs_osc_model pmcs_osc_model_i (.clk_in(clk_in), .nrst_in(nrst_in),
        .pri_en_in(p_en), .tmr_en_in(t_en), .rc_en_in(r_en),
        .slow_in(slow), .pri_ready_out(p_rdy), .tmr_run_out(t_run),
        .pri_clk_out(p_clk), .tmr_clk_out(t_clk), .rc_clk_out(r_clk));

    // ****************************************
    // Tasks
    // ****************************************
    task conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task chk(input logic [2:0] got, input logic [2:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_rng(input int n, input int lo, input int hi);
        num_checks++;
        if (n < lo || n > hi) begin
            num_errors++;
            $display("Error %0t: %0d cycles outside %0d..%0d",
                $time, n, lo, hi);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    function automatic logic [2:0] val(input int w);
        return (w == 0) ? src : (w == 1) ? {2'h0, exec} : {2'h0, t_run};
    endfunction
    // Bounded wait until a watched value matches
    task wait_on(input int w, input logic [2:0] want, output int n);
        n = 0;
        while (val(w) !== want && n < 2000) begin
            tick(1);
            n++;
        end
        if (n >= 2000) begin
            num_errors++;
            $display("Error %0t: wait timed out", $time);
            conclude();
        end
    endtask
    task sleep_op(input logic i);
        @(posedge clk_in);
        idle <= i;
        slp <= 1'b1;
        @(posedge clk_in);
        slp <= 1'b0;
        tick(2);
    endtask
    task pulse(input logic w);
        @(posedge clk_in);
        wdt <= w;
        irq <= !w;
        @(posedge clk_in);
        wdt <= 1'b0;
        irq <= 1'b0;
        #1;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        int n;
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        tick(1);
        chk(src, 3'h1);
        chk({f_pri, f_tmr, exec}, 3'h5);
        @(posedge clk_in);
        sel <= 2'h1;
        tick(80);
        chk({f_pri, f_tmr, src[1]}, 3'h4);
        @(posedge clk_in);
        sel <= 2'h2;
        ten <= 1'b1;
        wait_on(2, 3'h1, n);
        @(posedge clk_in);
        sel <= 2'h1;
        wait_on(0, 3'h2, n);
        chk_rng(n, 46, 76);
        tick(2);
        chk({f_pri, f_tmr, p_en}, 3'h2);
        sleep_op(1'b1);
        chk({cpu_en, per_en, exec}, 3'h2);
        chk({1'b0, f_pri, f_tmr}, 3'h1);
        pulse(1'b0);
        wait_on(1, 3'h1, n);
        chk_rng(n, pmcs_pkg::CPU_READY_CYCLES - 2,
            pmcs_pkg::CPU_READY_CYCLES + 4);
        chk(src, 3'h2);
        @(posedge clk_in);
        sel <= 2'h2;
        wait_on(0, 3'h1, n);
        tick(2);
        chk({f_pri, f_tmr, t_en}, 3'h5);
        chk({cpu_en, per_en, exec}, 3'h7);
        @(posedge clk_in);
        sel <= 2'h3;
        wait_on(0, 3'h4, n);
        chk_rng(n, 22, 44);
        tick(2);
        chk({f_pri, f_tmr, p_en}, 3'h0);
        @(posedge clk_in);
        slow <= 1'b1;
        sel <= 2'h2;
        tick(100);
        chk(src, 3'h4);
        wait_on(0, 3'h1, n);
        slow <= 1'b0;
        tick(2);
        chk({f_pri, f_tmr, r_en}, 3'h5);
        sleep_op(1'b0);
        chk({cpu_en, per_en, exec}, 3'h0);
        chk({f_pri, f_tmr, r_en}, 3'h1);
        chk({2'h0, t_en}, 3'h1);
        pulse(1'b1);
        wait_on(1, 3'h1, n);
        tick(2);
        chk(src, 3'h1);
        chk({f_pri, per_en, cpu_en}, 3'h7);
        pulse(1'b1);
        chk({1'b0, wd_rst, exec}, 3'h3);
        @(posedge clk_in);
        tsp <= 1'b1;
        sleep_op(1'b0);
        chk({cpu_en, per_en, exec}, 3'h0);
        pulse(1'b0);
        tick(3);
        chk({per_en, exec, cpu_en}, 3'h4);
        wait_on(1, 3'h1, n);
        chk_rng(n, pmcs_pkg::CPU_READY_CYCLES,
            pmcs_pkg::CPU_READY_CYCLES + 200);
        tick(5);
        conclude();
    end
endmodule
